// [common/zar_regs.svh]
// Offsets, field positions, reset values and timing counts of the output register bank.
`ifndef ZAR_REGS_SVH
`define ZAR_REGS_SVH

// Word offsets on the register port.
`define ZAR_OFS_SENSOR_STATUS 8'h23
`define ZAR_OFS_LEFT_SPEED    8'h28
`define ZAR_OFS_RIGHT_SPEED   8'h40
`define ZAR_OFS_UP_ACC_CTL    8'h68
`define ZAR_OFS_UP_RELEASE    8'h69
`define ZAR_OFS_UP_TRK_ONE    8'h84
`define ZAR_OFS_UP_TRK_TWO    8'h85
`define ZAR_OFS_DN_ACC_CTL    8'hB8
`define ZAR_OFS_DN_RELEASE    8'hB9
`define ZAR_OFS_DN_TRK_ONE    8'hD4
`define ZAR_OFS_DN_TRK_TWO    8'hD5

// Accumulation control word fields.
`define ZAR_ACC_BIT     0
`define ZAR_ADJ_UP_BIT  8
`define ZAR_ARR_CNF_BIT 9
`define ZAR_JOG_FWD_BIT 10
`define ZAR_JOG_REV_BIT 11
`define ZAR_WAKE_BIT    12

// Sensor status word fields.
`define ZAR_SNS_LEFT_BIT  4
`define ZAR_SNS_RIGHT_BIT 6
`define ZAR_HEARTBEAT_BIT 15

// Reset values.
`define ZAR_WORD_RST  16'h0000
`define ZAR_SPEED_RST 16'h0000

// Timing: clock rate, heartbeat half period and sensor settle time.
`define ZAR_CLK_KHZ         100000
`define ZAR_HB_HALF_MS      2000
`define ZAR_HB_HALF_CYC     (`ZAR_HB_HALF_MS * `ZAR_CLK_KHZ)
`define ZAR_SETTLE_MS       10
`define ZAR_SETTLE_CYC      (`ZAR_SETTLE_MS * `ZAR_CLK_KHZ)

`endif

// [common/zar_pkg.sv]
// Types shared by the output register bank modules.
package zar_pkg;
  typedef logic [15:0] zar_word_t;
  typedef enum logic {ZAR_ROLLER, ZAR_GEAR} zar_motor_e;
  typedef enum logic [1:0] {ZAR_CFG_SETTLE, ZAR_CFG_CAPTURE, ZAR_CFG_DONE} zar_cfg_e;
endpackage

// [core/zar_sensor_norm.sv]
// Sensor pin synchroniser with polarity chosen by automatic configuration.
`timescale 1ns/10ps
`default_nettype none
`include "zar_regs.svh"
module zar_sensor_norm
  import zar_pkg::*;
#(
  parameter int NUM    = 2,
  parameter int SETTLE = `ZAR_SETTLE_CYC
) (
  input  wire logic           i_clk,
  input  wire logic           i_arst_n,
  input  wire logic [NUM-1:0] i_pin,
  output logic      [NUM-1:0] o_blocked,
  output logic                o_cfg_done
);
  if (SETTLE < 1 || NUM < 1) begin : g_chk
    $error("zar_sensor_norm: SETTLE and NUM must be at least one");
  end

  logic [NUM-1:0] s1_q;
  logic [NUM-1:0] s2_q;
  logic [NUM-1:0] s3_q;
  logic [NUM-1:0] lvl_q;
  logic [NUM-1:0] inv_q;
  logic [31:0]    cnt_q;
  zar_cfg_e       st_q;

  // Three-stage synchroniser; the first stage feeds only the second.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A pin level counts once the second and third stages agree.
  for (genvar g = 0; g < NUM; g++) begin : g_lvl
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        lvl_q[g] <= 1'b0;
      end else if (s2_q[g] == s3_q[g]) begin
        lvl_q[g] <= s3_q[g];
      end
    end
  end

  // Configuration waits for the sensors to settle and takes the idle level as clear.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q  <= ZAR_CFG_SETTLE;
      cnt_q <= '0;
      inv_q <= '0;
    end else begin
      case (st_q)
        ZAR_CFG_SETTLE: begin
          cnt_q <= cnt_q + 32'd1;
          if (cnt_q == 32'(SETTLE - 1)) begin
            st_q <= ZAR_CFG_CAPTURE;
          end
        end
        ZAR_CFG_CAPTURE: begin
          inv_q <= lvl_q;
          st_q  <= ZAR_CFG_DONE;
        end
        default: begin
          st_q <= ZAR_CFG_DONE;
        end
      endcase
    end
  end

  // Blocked reads as one whatever the electrical polarity.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_blocked  <= '0;
      o_cfg_done <= 1'b0;
    end else begin
      o_cfg_done <= (st_q == ZAR_CFG_DONE);
      o_blocked  <= (st_q == ZAR_CFG_DONE) ? (lvl_q ^ inv_q) : '0;
    end
  end
endmodule
`default_nettype wire

// [core/zar_speed_hold.sv]
// Speed setpoint holder with zero hold and per motor type limits.
`timescale 1ns/10ps
`default_nettype none
`include "zar_regs.svh"
module zar_speed_hold
  import zar_pkg::*;
#(
  parameter logic [15:0] ROLLER_MIN = 16'h000A,
  parameter logic [15:0] ROLLER_MAX = 16'h0BB8,
  parameter logic [15:0] GEAR_MIN   = 16'h000A,
  parameter logic [15:0] GEAR_MAX   = 16'h07D0
) (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_wr,
  input  wire zar_word_t  i_data,
  input  wire zar_motor_e i_type,
  output zar_word_t       o_speed
);
  if (ROLLER_MIN > ROLLER_MAX || GEAR_MIN > GEAR_MAX || ROLLER_MIN == 16'h0000
      || GEAR_MIN == 16'h0000) begin : g_chk
    $error("zar_speed_hold: limits must be nonzero and ordered");
  end

  zar_word_t lo;
  zar_word_t hi;

  // Unit is mm/s for a roller and rpm times ten for a gear drive.
  always_comb begin
    lo = (i_type == ZAR_GEAR) ? GEAR_MIN : ROLLER_MIN;
    hi = (i_type == ZAR_GEAR) ? GEAR_MAX : ROLLER_MAX;
  end

  // Zero keeps the last nonzero setpoint; others clamp into range.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_speed <= `ZAR_SPEED_RST;
    end else if (i_wr && i_data != 16'h0000) begin
      if (i_data < lo) begin
        o_speed <= lo;
      end else if (i_data > hi) begin
        o_speed <= hi;
      end else begin
        o_speed <= i_data;
      end
    end
  end
endmodule
`default_nettype wire

// [core/zar_top.sv]
// Zone accumulation output register bank with sensor status readback.
//
// Functional notes
// - Sensor status bits read one when blocked, zero when clear, any polarity.
// - Polarity inversion per sensor chosen by automatic configuration after reset.
// - Two tracking words attach to the carton held in upstream zone.
// - Two tracking words attach to the carton held in downstream zone.
// - Control word bit 0 sets or clears local zone accumulation.
// - Control word bit 8 makes the adjacent upstream zone accumulate.
// - Control word bit 9 asserts arrival confirmation toward adjacent downstream zone.
// - Bit 10 alone jogs default direction, bit 11 alone jogs opposite direction.
// - Control word bit 12 wakes the local zone from idle.
// - Speed means mm/s for roller or rpm times ten for gear drive.
// - Writing zero speed keeps the last nonzero setpoint running.
// - Accepted speed is limited to the attached motor type's range.
// - Changing release register while accumulating releases carton and rearms accumulation.
// - Left sensor status at bit 4, right sensor at bit 6.
`timescale 1ns/10ps
`default_nettype none
`include "zar_regs.svh"
module zar_top
  import zar_pkg::*;
#(
  parameter int          SETTLE_CYC = `ZAR_SETTLE_CYC,
  parameter int          HB_HALF    = `ZAR_HB_HALF_CYC,
  parameter logic [15:0] ROLLER_MIN = 16'h000A,
  parameter logic [15:0] ROLLER_MAX = 16'h0BB8,
  parameter logic [15:0] GEAR_MIN   = 16'h000A,
  parameter logic [15:0] GEAR_MAX   = 16'h07D0
) (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_zone_accumulation_mode,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_addr,
  input  wire zar_word_t  i_wr_data,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_rd_addr,
  output zar_word_t       o_rd_data,
  input  wire logic       i_left_sensor_pin,
  input  wire logic       i_right_sensor_pin,
  input  wire zar_motor_e i_left_motor_type,
  input  wire zar_motor_e i_right_motor_type,
  output zar_word_t       o_left_speed,
  output zar_word_t       o_right_speed,
  output logic [1:0]      o_zone_accum,
  output logic [1:0]      o_adj_up_accum,
  output logic [1:0]      o_arrival_confirm,
  output logic [1:0]      o_jog_fwd,
  output logic [1:0]      o_jog_rev,
  output logic [1:0]      o_wake,
  output logic [1:0]      o_release,
  output zar_word_t       o_up_trk_one,
  output zar_word_t       o_up_trk_two,
  output zar_word_t       o_dn_trk_one,
  output zar_word_t       o_dn_trk_two,
  output logic            o_cfg_done
);
  if (HB_HALF < 2) begin : g_chk
    $error("zar_top: HB_HALF must be at least two");
  end

  // Index 0 is the local upstream zone, index 1 the local downstream zone.
  localparam logic [7:0] ACC_OFS [2] = '{`ZAR_OFS_UP_ACC_CTL, `ZAR_OFS_DN_ACC_CTL};
  localparam logic [7:0] REL_OFS [2] = '{`ZAR_OFS_UP_RELEASE, `ZAR_OFS_DN_RELEASE};

  // Hit test of a write or read address against one offset, used for every register.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic        wr;
  logic [1:0]  blocked;
  zar_word_t   ctl_q [2];
  zar_word_t   rel_q [2];
  logic [31:0] hb_cnt_q;
  logic        hb_q;

  // Writes count only while the module runs in zone accumulation mode.
  assign wr = i_wr_en & i_zone_accumulation_mode;

  // Sensor synchronisation and polarity normalisation.
  zar_sensor_norm #(
    .NUM    (2),
    .SETTLE (SETTLE_CYC)
  ) u_sns (
    .i_clk      (i_clk),
    .i_arst_n   (i_arst_n),
    .i_pin      ({i_right_sensor_pin, i_left_sensor_pin}),
    .o_blocked  (blocked),
    .o_cfg_done (o_cfg_done)
  );

  // Left motor speed setpoint.
  zar_speed_hold #(
    .ROLLER_MIN (ROLLER_MIN),
    .ROLLER_MAX (ROLLER_MAX),
    .GEAR_MIN   (GEAR_MIN),
    .GEAR_MAX   (GEAR_MAX)
  ) u_left_spd (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_wr     (wr && hit(i_wr_addr, `ZAR_OFS_LEFT_SPEED)),
    .i_data   (i_wr_data),
    .i_type   (i_left_motor_type),
    .o_speed  (o_left_speed)
  );

  // Right motor speed setpoint.
  zar_speed_hold #(
    .ROLLER_MIN (ROLLER_MIN),
    .ROLLER_MAX (ROLLER_MAX),
    .GEAR_MIN   (GEAR_MIN),
    .GEAR_MAX   (GEAR_MAX)
  ) u_right_spd (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_wr     (wr && hit(i_wr_addr, `ZAR_OFS_RIGHT_SPEED)),
    .i_data   (i_wr_data),
    .i_type   (i_right_motor_type),
    .o_speed  (o_right_speed)
  );

  // Tracking words of the carton held in each zone.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_up_trk_one <= `ZAR_WORD_RST;
      o_up_trk_two <= `ZAR_WORD_RST;
      o_dn_trk_one <= `ZAR_WORD_RST;
      o_dn_trk_two <= `ZAR_WORD_RST;
    end else if (wr) begin
      if (hit(i_wr_addr, `ZAR_OFS_UP_TRK_ONE)) begin
        o_up_trk_one <= i_wr_data;
      end else if (hit(i_wr_addr, `ZAR_OFS_UP_TRK_TWO)) begin
        o_up_trk_two <= i_wr_data;
      end else if (hit(i_wr_addr, `ZAR_OFS_DN_TRK_ONE)) begin
        o_dn_trk_one <= i_wr_data;
      end else if (hit(i_wr_addr, `ZAR_OFS_DN_TRK_TWO)) begin
        o_dn_trk_two <= i_wr_data;
      end
    end
  end

  // Per-zone control word, release register and decoded outputs.
  for (genvar z = 0; z < 2; z++) begin : g_zone
    // Control word store; reserved bits are kept but drive nothing.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        ctl_q[z] <= `ZAR_WORD_RST;
      end else if (wr && hit(i_wr_addr, ACC_OFS[z])) begin
        ctl_q[z] <= i_wr_data;
      end
    end

    // Control outputs follow the stored word one cycle after the write.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        o_zone_accum[z]      <= 1'b0;
        o_adj_up_accum[z]    <= 1'b0;
        o_arrival_confirm[z] <= 1'b0;
        o_wake[z]            <= 1'b0;
      end else begin
        o_zone_accum[z]      <= ctl_q[z][`ZAR_ACC_BIT];
        o_adj_up_accum[z]    <= ctl_q[z][`ZAR_ADJ_UP_BIT];
        o_arrival_confirm[z] <= ctl_q[z][`ZAR_ARR_CNF_BIT];
        o_wake[z]            <= ctl_q[z][`ZAR_WAKE_BIT];
      end
    end

    // Jog runs while its bit stands; both bits together cancel to avoid a fight.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        o_jog_fwd[z] <= 1'b0;
        o_jog_rev[z] <= 1'b0;
      end else begin
        o_jog_fwd[z] <= ctl_q[z][`ZAR_JOG_FWD_BIT] & ~ctl_q[z][`ZAR_JOG_REV_BIT];
        o_jog_rev[z] <= ctl_q[z][`ZAR_JOG_REV_BIT] & ~ctl_q[z][`ZAR_JOG_FWD_BIT];
      end
    end

    // A changed release value while accumulating gives a one-cycle release pulse.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        rel_q[z]     <= `ZAR_WORD_RST;
        o_release[z] <= 1'b0;
      end else begin
        o_release[z] <= 1'b0;
        if (wr && hit(i_wr_addr, REL_OFS[z])) begin
          rel_q[z] <= i_wr_data;
          if (ctl_q[z][`ZAR_ACC_BIT] && i_wr_data != rel_q[z]) begin
            o_release[z] <= 1'b1;
          end
        end
      end
    end
  end

  // Heartbeat toggles every half period for the status word.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hb_cnt_q <= '0;
      hb_q     <= 1'b0;
    end else if (hb_cnt_q == 32'(HB_HALF - 1)) begin
      hb_cnt_q <= '0;
      hb_q     <= ~hb_q;
    end else begin
      hb_cnt_q <= hb_cnt_q + 32'd1;
    end
  end

  // Read port: only the sensor status word is readable; other addresses read zero.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= '0;
    end else if (i_rd_en) begin
      o_rd_data <= '0;
      if (hit(i_rd_addr, `ZAR_OFS_SENSOR_STATUS)) begin
        o_rd_data[`ZAR_SNS_LEFT_BIT]  <= blocked[0];
        o_rd_data[`ZAR_SNS_RIGHT_BIT] <= blocked[1];
        o_rd_data[`ZAR_HEARTBEAT_BIT] <= hb_q;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/zar_checker_assertions.sv]
// Concurrent checks on the ports of the output register bank.
`timescale 1ns/10ps
`default_nettype none
`include "zar_regs.svh"
module zar_checker
  import zar_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic       i_zone_accumulation_mode,
  input wire logic       i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire zar_word_t  i_wr_data,
  input wire zar_word_t  o_left_speed,
  input wire logic [1:0] o_zone_accum,
  input wire logic [1:0] o_adj_up_accum,
  input wire logic [1:0] o_arrival_confirm,
  input wire logic [1:0] o_jog_fwd,
  input wire logic [1:0] o_jog_rev,
  input wire logic [1:0] o_wake,
  input wire logic [1:0] o_release,
  input wire zar_word_t  o_up_trk_one,
  input wire zar_word_t  o_up_trk_two,
  input wire zar_word_t  o_dn_trk_two
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // A write counts only while the bank is in accumulation mode.
  logic wv;
  assign wv = i_wr_en & i_zone_accumulation_mode;
  // Tracking words are visible at the edge after the write that carries them.
  property p_trk_up;
    (wv && i_wr_addr == `ZAR_OFS_UP_TRK_ONE) |=> o_up_trk_one == $past(i_wr_data);
  endproperty
  a_trk_up: assert property (p_trk_up)
    else $error("upstream tracking word not taken");
  property p_trk_dn;
    (wv && i_wr_addr == `ZAR_OFS_DN_TRK_TWO) |=> o_dn_trk_two == $past(i_wr_data);
  endproperty
  a_trk_dn: assert property (p_trk_dn)
    else $error("downstream tracking word not taken");
  // Control outputs show the written word two edges after the write.
  property p_accum;
    (wv && i_wr_addr == `ZAR_OFS_UP_ACC_CTL)
      |-> ##2 o_zone_accum[0] == $past(i_wr_data[`ZAR_ACC_BIT], 2);
  endproperty
  a_accum: assert property (p_accum)
    else $error("zone accumulation does not follow bit 0");
  property p_adj;
    (wv && i_wr_addr == `ZAR_OFS_DN_ACC_CTL)
      |-> ##2 o_adj_up_accum[1] == $past(i_wr_data[`ZAR_ADJ_UP_BIT], 2);
  endproperty
  a_adj: assert property (p_adj)
    else $error("adjacent accumulate does not follow bit 8");
  property p_cnf;
    (wv && i_wr_addr == `ZAR_OFS_UP_ACC_CTL)
      |-> ##2 o_arrival_confirm[0] == $past(i_wr_data[`ZAR_ARR_CNF_BIT], 2);
  endproperty
  a_cnf: assert property (p_cnf)
    else $error("arrival confirm does not follow bit 9");
  property p_jog;
    (wv && i_wr_addr == `ZAR_OFS_UP_ACC_CTL && i_wr_data[11:10] == 2'b01)
      |-> ##[1:3] (o_jog_fwd[0] && !o_jog_rev[0]);
  endproperty
  a_jog: assert property (p_jog)
    else $error("forward jog missing");
  property p_wake;
    (wv && i_wr_addr == `ZAR_OFS_DN_ACC_CTL)
      |-> ##2 o_wake[1] == $past(i_wr_data[`ZAR_WAKE_BIT], 2);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake does not follow bit 12");
  property p_zero;
    (wv && i_wr_addr == `ZAR_OFS_LEFT_SPEED && i_wr_data == 16'h0000) |=> $stable(o_left_speed)[*3];
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero speed write changed the setpoint");
  // A pulse with no further release write behind it lasts one cycle.
  property p_rel;
    (o_release[0] && !(wv && i_wr_addr == `ZAR_OFS_UP_RELEASE)) |=> !o_release[0];
  endproperty
  a_rel: assert property (p_rel)
    else $error("release pulse longer than one cycle");
  // A release pulse only ever follows a write to the release register.
  property p_rel_src;
    o_release[0] |-> $past(wv && i_wr_addr == `ZAR_OFS_UP_RELEASE);
  endproperty
  a_rel_src: assert property (p_rel_src)
    else $error("release pulse without a release write");
  property p_hold;
    (!i_wr_en)[*4] |-> ($stable(o_up_trk_two) && $stable(o_zone_accum) && $stable(o_left_speed));
  endproperty
  a_hold: assert property (p_hold)
    else $error("held register changed without a write");
endmodule
bind zar_top zar_checker u_chk (.*);
`default_nettype wire

// [tb/zar_host_model.sv]
// Host model that writes and reads the register bank like a network controller.
`timescale 1ns/10ps
`default_nettype none
module zar_host_model
  import zar_pkg::*;
(
  input  wire logic      i_clk,
  input  wire zar_word_t i_rd_data,
  output logic           o_wr_en,
  output logic [7:0]     o_wr_addr,
  output zar_word_t      o_wr_data,
  output logic           o_rd_en,
  output logic [7:0]     o_rd_addr
);
  // Bus idles with both strobes low.
  initial begin
    o_wr_en   = 1'b0;
    o_wr_addr = 8'h00;
    o_wr_data = 16'h0000;
    o_rd_en   = 1'b0;
    o_rd_addr = 8'h00;
  end
  // One whole word for one cycle; released data lines are scrambled.
  task automatic wr(input logic [7:0] a, input zar_word_t d);
    @(negedge i_clk);
    o_wr_en   = 1'b1;
    o_wr_addr = a;
    o_wr_data = d;
    @(negedge i_clk);
    o_wr_en   = 1'b0;
    o_wr_data = ~d;
  endtask
  // Control words go out with reserved bits cleared.
  task automatic ctl(input logic [7:0] a, input zar_word_t d);
    wr(a, d & 16'h1F01);
  endtask
  // Read data is taken one cycle after the strobe.
  task automatic rd(input logic [7:0] a, output zar_word_t d);
    @(negedge i_clk);
    o_rd_en   = 1'b1;
    o_rd_addr = a;
    @(negedge i_clk);
    o_rd_en   = 1'b0;
    d         = i_rd_data;
  endtask
endmodule
`default_nettype wire

// [tb/zar_tb_top.sv]
// Self-checking bench for the output register bank.
`timescale 1ns/10ps
`default_nettype none
`include "zar_regs.svh"
module zar_tb_top
  import zar_pkg::*;
;
  localparam zar_word_t RMIN = 16'h000A;
  localparam zar_word_t RMAX = 16'h0BB8;
  localparam zar_word_t GMIN = 16'h000A;
  localparam zar_word_t GMAX = 16'h07D0;
  logic       clk = 1'b0, arst_n = 1'b0, mode = 1'b0, lpin = 1'b1, rpin = 1'b0, cfg;
  logic       wr_en, rd_en;
  logic [7:0] wa, ra;
  logic [1:0] acc, adj, cnf, jf, jr, wk, rel;
  zar_word_t  wd, rdd, ls, rs, t1, t2, t3, t4;
  int         err_total = 0, check_count = 0;
  zar_motor_e ltype = ZAR_ROLLER, rtype = ZAR_GEAR;
  always #5 clk = ~clk;
  zar_host_model host (.i_clk(clk), .i_rd_data(rdd), .o_wr_en(wr_en), .o_wr_addr(wa),
    .o_wr_data(wd), .o_rd_en(rd_en), .o_rd_addr(ra));
  zar_top #(.SETTLE_CYC(8), .HB_HALF(16)) uut (.i_clk(clk), .i_arst_n(arst_n),
    .i_zone_accumulation_mode(mode), .i_wr_en(wr_en), .i_wr_addr(wa), .i_wr_data(wd),
    .i_rd_en(rd_en), .i_rd_addr(ra), .o_rd_data(rdd), .i_left_sensor_pin(lpin),
    .i_right_sensor_pin(rpin), .i_left_motor_type(ltype), .i_right_motor_type(rtype),
    .o_left_speed(ls), .o_right_speed(rs), .o_zone_accum(acc), .o_adj_up_accum(adj),
    .o_arrival_confirm(cnf), .o_jog_fwd(jf), .o_jog_rev(jr), .o_wake(wk), .o_release(rel),
    .o_up_trk_one(t1), .o_up_trk_two(t2), .o_dn_trk_one(t3), .o_dn_trk_two(t4),
    .o_cfg_done(cfg));
  // Counts a comparison and reports a mismatch.
  task automatic chk(input zar_word_t got, input zar_word_t exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Sensors are clear at configuration, then blocked one at a time.
  task automatic t_sensor();
    int n = 0;
    zar_word_t d;
    while (cfg !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (cfg !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t configuration never finished", $time);
      close_out();
    end
    host.rd(`ZAR_OFS_SENSOR_STATUS, d);
    chk(d & 16'h0050, 16'h0000);
    lpin = 1'b0;
    repeat (8) @(negedge clk);
    host.rd(`ZAR_OFS_SENSOR_STATUS, d);
    chk(d & 16'h0050, 16'h0010);
    rpin = 1'b1;
    repeat (8) @(negedge clk);
    host.rd(`ZAR_OFS_SENSOR_STATUS, d);
    chk(d & 16'h0050, 16'h0050);
  endtask
  // Tracking words, a refused write and an unmapped place.
  task automatic t_trk();
    zar_word_t d;
    host.wr(`ZAR_OFS_UP_TRK_ONE, 16'hA1B2);
    host.wr(`ZAR_OFS_UP_TRK_TWO, 16'hC3D4);
    host.wr(`ZAR_OFS_DN_TRK_ONE, 16'h5E6F);
    host.wr(`ZAR_OFS_DN_TRK_TWO, 16'h7081);
    mode = 1'b0;
    host.wr(`ZAR_OFS_UP_TRK_ONE, 16'h0000);
    mode = 1'b1;
    host.wr(8'h00, 16'hFFFF);
    host.rd(8'h00, d);
    chk(d, 16'h0000);
    chk(t1, 16'hA1B2);
    chk(t2, 16'hC3D4);
    chk(t3, 16'h5E6F);
    chk(t4, 16'h7081);
  endtask
  // Each defined control bit in turn, then both jog bits together.
  task automatic t_ctl();
    int b[6] = '{0, 8, 9, 10, 11, 12};
    for (int i = 0; i < 7; i++) begin
      host.ctl(`ZAR_OFS_UP_ACC_CTL, (i < 6) ? 16'h0001 << b[i] : 16'h0C00);
      host.ctl(`ZAR_OFS_DN_ACC_CTL, (i < 6) ? 16'h0001 << b[i] : 16'h0C00);
      repeat (3) @(negedge clk);
      chk(16'({acc[0], adj[0], cnf[0], jf[0], jr[0], wk[0]}), 16'h0020 >> i);
      chk(16'({acc[1], adj[1], cnf[1], jf[1], jr[1], wk[1]}), 16'h0020 >> i);
    end
  endtask
  // Writes a release word and counts the pulses that follow.
  task automatic pulses(input logic [7:0] a, input zar_word_t d, input int z, input int n);
    int c = 0;
    host.wr(a, d);
    repeat (4) begin
      if (rel[z] === 1'b1) c++;
      @(negedge clk);
    end
    chk(16'(c), 16'(n));
  endtask
  // Release fires on a changed value only while the zone accumulates.
  task automatic t_rel(input logic [7:0] ca, input logic [7:0] rla, input int z);
    host.ctl(ca, 16'h0001);
    pulses(rla, 16'h0007, z, 1);
    pulses(rla, 16'h0007, z, 0);
    host.ctl(ca, 16'h0000);
    pulses(rla, 16'h0009, z, 0);
  endtask
  // Setpoints, zero hold and clamping for roller left and gear drive right.
  task automatic t_spd();
    zar_word_t v[5]  = '{16'd400, 16'd0, 16'd5000, 16'd0, 16'd5};
    zar_word_t el[5] = '{16'd400, 16'd400, RMAX, RMAX, RMIN};
    zar_word_t er[5] = '{16'd400, 16'd400, GMAX, GMAX, GMIN};
    for (int i = 0; i < 5; i++) begin
      host.wr(`ZAR_OFS_LEFT_SPEED, v[i]);
      host.wr(`ZAR_OFS_RIGHT_SPEED, v[i]);
      repeat (3) @(negedge clk);
      chk(ls, el[i]);
      chk(rs, er[i]);
    end
    // Swapped motor types: the limits follow the type present at the write.
    ltype = ZAR_GEAR;
    rtype = ZAR_ROLLER;
    host.wr(`ZAR_OFS_LEFT_SPEED, 16'd5000);
    host.wr(`ZAR_OFS_RIGHT_SPEED, 16'd5000);
    repeat (3) @(negedge clk);
    chk(ls, GMAX);
    chk(rs, RMAX);
  endtask
  // Main sequence.
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    mode   = 1'b1;
    t_sensor();
    t_trk();
    t_ctl();
    t_rel(`ZAR_OFS_UP_ACC_CTL, `ZAR_OFS_UP_RELEASE, 0);
    t_rel(`ZAR_OFS_DN_ACC_CTL, `ZAR_OFS_DN_RELEASE, 1);
    t_spd();
    close_out();
  end
endmodule
`default_nettype wire
